// File: verilog/sit_interval_timer.sv
// The APB register port and the placing of the registers were decided locally.
`timescale 1ns/100ps
`default_nettype none
module sit_interval_timer (
   input  wire logic                               clk_sys_in,     // 20 MHz system clock.
   input  wire logic                               arst_n_in,      // Asynchronous reset, active low.
   input  wire logic                               sub_clk_in,     // Sub clock pin, asynchronous.
   input  wire logic [sit_pkg::WD_TAP_COUNT-1:0]   tbt_tap_in,     // Time-base timer taps, same clock.
   input  wire logic                               psel,           // APB select.
   input  wire logic                               penable,        // APB enable.
   input  wire logic                               pwrite,         // APB direction.
   input  wire logic [7:0]                         paddr,          // APB byte address.
   input  wire logic [31:0]                        pwdata,         // APB write data.
   output logic [31:0]                             prdata,         // APB read data.
   output logic                                    pready,         // APB ready.
   output logic                                    pslverr,        // APB error on unmapped address.
   output logic [sit_pkg::CNT_WIDTH-1:0]           stab_tap_out,   // Counter value for the stabilisation timer.
   output logic [sit_pkg::WD_TAP_COUNT-1:0]        wd_tap_out,     // Watchdog count taps after selection.
   output logic                                    irq28_req_out,  // Interval overflow request, number 28.
   output logic                                    irq_out         // Summary interrupt, status ANDed with int_mask.
);
   logic [sit_pkg::CNT_WIDTH-1:0] count;
   logic [sit_pkg::CNT_WIDTH-1:0] next_count;
   logic [sit_pkg::CNT_WIDTH-1:0] carry;
   sit_pkg::sit_control_type      control;
   sit_pkg::sit_control_type      next_control;
   logic [sit_pkg::EV_WIDTH-1:0]  int_status;
   logic [sit_pkg::EV_WIDTH-1:0]  int_mask;
   logic [sit_pkg::EV_WIDTH-1:0]  events;
   logic [sit_pkg::EV_WIDTH-1:0]  stat_clear;
   logic                          sub_tick;
   logic                          setup_rd;
   logic                          access;
   logic                          wr;
   logic                          rd;
   logic                          hit_control;
   logic                          hit_count;
   logic                          hit_stat;
   logic                          hit_mask;
   logic                          mapped;
   logic                          soft_clear;
   logic                          sel_valid;
   logic [3:0]                    tap_index;
   logic                          ovf_event;
   logic                          wrap_event;
   logic [31:0]                   read_mux;

   // The sub clock is sampled, not used as a clock, so the whole block stays on one clock tree.
   sit_pin_sync u_sub_sync (
      .clk_sys_in (clk_sys_in),
      .arst_n_in  (arst_n_in),
      .pin_in     (sub_clk_in),
      .level_out  (),
      .rise_out   (sub_tick)
   );

   // Carry chain: carry[i] is high when bits i..0 are all ones.
   genvar gi;
   generate
      for (gi = 0; gi < sit_pkg::CNT_WIDTH; gi++) begin : g_carry
         if (gi == 0) begin : g_first
            assign carry[gi] = count[0];
         end else begin : g_rest
            assign carry[gi] = carry[gi-1] & count[gi];
         end
      end
   endgenerate

   assign access      = psel & penable;
   assign wr          = access & pwrite;
   assign rd          = access & ~pwrite;
   // Read data is loaded at the setup edge, so it already stands when the access edge samples it.
   assign setup_rd    = psel & ~penable & ~pwrite;
   assign hit_control = (paddr == sit_pkg::OFS_CONTROL);
   assign hit_count   = (paddr == sit_pkg::OFS_COUNT);
   assign hit_stat    = (paddr == sit_pkg::OFS_INT_STAT);
   assign hit_mask    = (paddr == sit_pkg::OFS_INT_MASK);
   assign mapped      = hit_control | hit_count | hit_stat | hit_mask;
   assign pready      = 1'b1;
   assign pslverr     = access & ~mapped;
   assign soft_clear  = wr & hit_control & pwdata[sit_pkg::CTL_CLR_BIT];

   // Intervals: code n watches carry out of bit n+7, giving two to the n+8 sub clocks.
   assign sel_valid   = (control.interval_select != sit_pkg::SEL_RESERVED);
   assign tap_index   = 4'(control.interval_select) + 4'(sit_pkg::MIN_TAP_BIT);
   assign ovf_event   = sub_tick & sel_valid & carry[tap_index] & ~soft_clear;
   assign wrap_event  = sub_tick & carry[sit_pkg::CNT_WIDTH-1] & ~soft_clear;
   assign events      = {wrap_event, ovf_event};

   // Counting ignores every clock selection setting; only the sub clock tick advances it.
   always_comb begin
      next_count = count;
      if (soft_clear) begin
         next_count = '0;
      end else if (sub_tick) begin
         next_count = count + 1'b1;
      end
   end

   always_comb begin
      next_control = control;
      if (wr && hit_control) begin
         next_control.interval_select        = pwdata[sit_pkg::CTL_SEL_LSB +: sit_pkg::SEL_WIDTH];
         next_control.overflow_irq_enable    = pwdata[sit_pkg::CTL_IE_BIT];
         next_control.watchdog_source_select = pwdata[sit_pkg::CTL_WDSRC_BIT];
         if (!pwdata[sit_pkg::CTL_OVF_BIT]) begin
            next_control.interval_overflow_flag = 1'b0;
         end
      end
      if (ovf_event) begin
         next_control.interval_overflow_flag = 1'b1;
      end
   end

   // Only the bits already reported are cleared, so an event landing after the setup edge is not lost.
   assign stat_clear = (rd && hit_stat) ? prdata[sit_pkg::EV_WIDTH-1:0] : '0;

   always_comb begin
      read_mux = 32'h0;
      if (hit_control) begin
         read_mux[sit_pkg::CTL_SEL_LSB +: sit_pkg::SEL_WIDTH] = control.interval_select;
         read_mux[sit_pkg::CTL_IE_BIT]    = control.overflow_irq_enable;
         read_mux[sit_pkg::CTL_OVF_BIT]   = control.interval_overflow_flag;
         read_mux[sit_pkg::CTL_WDSRC_BIT] = control.watchdog_source_select;
      end else if (hit_count) begin
         read_mux[sit_pkg::CNT_WIDTH-1:0] = count;
      end else if (hit_stat) begin
         read_mux[sit_pkg::EV_WIDTH-1:0]  = int_status;
      end else if (hit_mask) begin
         read_mux[sit_pkg::EV_WIDTH-1:0]  = int_mask;
      end
   end

   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         count      <= '0;
         control    <= sit_pkg::CONTROL_RESET;
         int_status <= '0;
         int_mask   <= sit_pkg::MASK_RESET;
         prdata     <= 32'h0;
      end else begin
         count      <= next_count;
         control    <= next_control;
         int_status <= (int_status & ~stat_clear) | events;
         if (wr && hit_mask) begin
            int_mask <= pwdata[sit_pkg::EV_WIDTH-1:0];
         end
         if (setup_rd) begin
            prdata <= read_mux;
         end
      end
   end

   // The stabilisation taps are raw counter bits, the watchdog taps counter bits 14..11 or the time-base taps; each consumer divides further on its own side.
   assign stab_tap_out  = count;
   assign wd_tap_out    = control.watchdog_source_select ?
                          count[sit_pkg::WD_TAP_LOW +: sit_pkg::WD_TAP_COUNT] : tbt_tap_in;
   assign irq28_req_out = control.interval_overflow_flag & control.overflow_irq_enable;
   assign irq_out       = |(int_status & int_mask);

   chk_count_advances: assert property (
      @(posedge clk_sys_in) disable iff (!arst_n_in)
      (sub_tick && !soft_clear) |=> (count == $past(count) + 15'h1))
      else $error("counter did not advance on a sub clock tick");

   chk_count_holds: assert property (
      @(posedge clk_sys_in) disable iff (!arst_n_in)
      (!sub_tick && !soft_clear) |=> $stable(count))
      else $error("counter moved without a sub clock tick");

   chk_overflow_sets: assert property (
      @(posedge clk_sys_in) disable iff (!arst_n_in)
      (sub_tick && sel_valid && !soft_clear && (&count[tap_index -: 1]) && carry[tap_index])
      |=> control.interval_overflow_flag)
      else $error("selected carry did not set the overflow flag");

   chk_flag_cause: assert property (
      @(posedge clk_sys_in) disable iff (!arst_n_in)
      $rose(control.interval_overflow_flag) |->
      (15'(count << (4'd14 - $past(tap_index))) == 15'h0) &&
      ($past(control.interval_select) != sit_pkg::SEL_RESERVED))
      else $error("overflow flag rose away from the selected interval boundary");

   chk_reserved_quiet: assert property (
      @(posedge clk_sys_in) disable iff (!arst_n_in)
      (control.interval_select == sit_pkg::SEL_RESERVED) |-> !ovf_event)
      else $error("reserved interval code produced an overflow");

   chk_irq_follows: assert property (
      @(posedge clk_sys_in) disable iff (!arst_n_in)
      $rose(control.interval_overflow_flag) ##0 control.overflow_irq_enable |-> irq28_req_out ##1
      (irq28_req_out || !control.interval_overflow_flag || !control.overflow_irq_enable))
      else $error("overflow request not raised with enable set");

   chk_flag_write_zero: assert property (
      @(posedge clk_sys_in) disable iff (!arst_n_in)
      (wr && hit_control && !pwdata[sit_pkg::CTL_OVF_BIT] && !ovf_event) |=> !control.interval_overflow_flag)
      else $error("writing zero did not clear the overflow flag");

   chk_flag_write_one: assert property (
      @(posedge clk_sys_in) disable iff (!arst_n_in)
      (wr && hit_control && pwdata[sit_pkg::CTL_OVF_BIT]) |=>
      (control.interval_overflow_flag == ($past(control.interval_overflow_flag) || $past(ovf_event))))
      else $error("writing one changed the overflow flag");

   chk_clear_zero: assert property (
      @(posedge clk_sys_in) disable iff (!arst_n_in)
      soft_clear |=> (count == '0) ##1 (count <= 15'h1))
      else $error("counter clear did not return the counter to zero");

   chk_wd_select: assert property (
      @(posedge clk_sys_in) disable iff (!arst_n_in)
      control.watchdog_source_select |-> (wd_tap_out == count[14:11]))
      else $error("watchdog taps not taken from the interval counter");

   // The checks below guard the tick path, the counter, the flag, the status bits, the request and the watchdog taps, which a short run reaches only partly.
   chk_tick_single: assert property (
      @(posedge clk_sys_in) disable iff (!arst_n_in)
      sub_tick
      |=> !sub_tick)
      else $error("one sub clock rise gave more than one tick");

   chk_count_wraps: assert property (
      @(posedge clk_sys_in) disable iff (!arst_n_in)
      (sub_tick && !soft_clear && (count == 15'h7fff))
      |=> (count == 15'h0))
      else $error("counter did not wrap to zero");

   chk_wrap_status: assert property (
      @(posedge clk_sys_in) disable iff (!arst_n_in)
      wrap_event
      |=> int_status[sit_pkg::EV_WRAP])
      else $error("counter wrap did not set its status bit");

   chk_tick_needed: assert property (
      @(posedge clk_sys_in) disable iff (!arst_n_in)
      !sub_tick
      |-> !ovf_event)
      else $error("overflow event without a sub clock tick");

   chk_no_tick_flag: assert property (
      @(posedge clk_sys_in) disable iff (!arst_n_in)
      !sub_tick
      |=> !$rose(control.interval_overflow_flag))
      else $error("overflow flag rose without a sub clock tick");

   chk_code_range: assert property (
      @(posedge clk_sys_in) disable iff (!arst_n_in)
      sel_valid
      |-> (tap_index >= 4'd7) && (tap_index <= 4'd13))
      else $error("valid interval code watches a carry outside the interval range");

   chk_status_sets: assert property (
      @(posedge clk_sys_in) disable iff (!arst_n_in)
      ovf_event
      |=> int_status[sit_pkg::EV_OVERFLOW])
      else $error("overflow event did not set its status bit");

   chk_irq_disabled: assert property (
      @(posedge clk_sys_in) disable iff (!arst_n_in)
      !control.overflow_irq_enable
      |-> !irq28_req_out)
      else $error("overflow request raised with the enable clear");

   chk_irq_level: assert property (
      @(posedge clk_sys_in) disable iff (!arst_n_in)
      (control.interval_overflow_flag && control.overflow_irq_enable)
      |-> irq28_req_out)
      else $error("overflow request missing while flag and enable are set");

   chk_stab_follows: assert property (
      @(posedge clk_sys_in) disable iff (!arst_n_in)
      (sub_tick && !soft_clear)
      |=> (stab_tap_out == $past(stab_tap_out) + 15'h1))
      else $error("stabilisation taps did not follow the counter");

   chk_clear_no_event: assert property (
      @(posedge clk_sys_in) disable iff (!arst_n_in)
      soft_clear
      |-> !ovf_event && !wrap_event)
      else $error("event raised in the cycle of a counter clear");

   chk_wd_time_base: assert property (
      @(posedge clk_sys_in) disable iff (!arst_n_in)
      !control.watchdog_source_select
      |-> (wd_tap_out == tbt_tap_in))
      else $error("watchdog taps not taken from the time-base taps");

   chk_flag_holds: assert property (
      @(posedge clk_sys_in) disable iff (!arst_n_in)
      (!ovf_event && !(wr && hit_control))
      |=> $stable(control.interval_overflow_flag))
      else $error("overflow flag changed without event or write");
endmodule : sit_interval_timer
`default_nettype wire

// File: verilog/sit_pkg.sv
`default_nettype none
package sit_pkg;
   localparam int          CNT_WIDTH     = 15;
   localparam int          SEL_WIDTH     = 3;
   localparam int          MIN_TAP_BIT   = 7;
   localparam logic [2:0]  SEL_RESERVED  = 3'h7;
   localparam logic [2:0]  SEL_RESET     = 3'h0;
   localparam int          IRQ_NUMBER    = 28;
   localparam int          WD_TAP_LOW    = 11;
   localparam int          WD_TAP_COUNT  = 4;
   localparam int          CLK_SYS_HZ    = 20000000;
   localparam int          SUB_CLK_HZ    = 8192;
   localparam int          SUB_HALF_CYC  = CLK_SYS_HZ / (2 * SUB_CLK_HZ);

   localparam logic [7:0]  OFS_CONTROL   = 8'h00;
   localparam logic [7:0]  OFS_COUNT     = 8'h04;
   localparam logic [7:0]  OFS_INT_STAT  = 8'h08;
   localparam logic [7:0]  OFS_INT_MASK  = 8'h0c;

   localparam int          CTL_SEL_LSB   = 0;
   localparam int          CTL_IE_BIT    = 3;
   localparam int          CTL_OVF_BIT   = 4;
   localparam int          CTL_WDSRC_BIT = 5;
   localparam int          CTL_CLR_BIT   = 6;

   localparam int          EV_OVERFLOW   = 0;
   localparam int          EV_WRAP       = 1;
   localparam int          EV_WIDTH      = 2;
   localparam logic [1:0]  MASK_RESET    = 2'h0;

   typedef struct packed {
      logic       watchdog_source_select;
      logic       interval_overflow_flag;
      logic       overflow_irq_enable;
      logic [2:0] interval_select;
   } sit_control_type;

   localparam sit_control_type CONTROL_RESET = '{1'b0, 1'b0, 1'b0, SEL_RESET};
endpackage : sit_pkg
`default_nettype wire

// File: verilog/sit_pin_sync.sv
`timescale 1ns/100ps
`default_nettype none
module sit_pin_sync (
   input  wire logic clk_sys_in,      // System clock.
   input  wire logic arst_n_in,       // Asynchronous reset, active low.
   input  wire logic pin_in,          // Asynchronous pin level.
   output logic      level_out,       // Filtered level.
   output logic      rise_out         // One-cycle pulse on accepted rising edge.
);
   logic stage1;
   logic stage2;
   logic stage3;
   logic agree;

   assign agree = (stage2 == stage3);

   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         stage1    <= 1'b0;
         stage2    <= 1'b0;
         stage3    <= 1'b0;
         level_out <= 1'b0;
         rise_out  <= 1'b0;
      end else begin
         stage1    <= pin_in;
         stage2    <= stage1;
         stage3    <= stage2;
         rise_out  <= agree & stage3 & ~level_out;
         if (agree) begin
            level_out <= stage3;
         end
      end
   end
endmodule : sit_pin_sync
`default_nettype wire

// File: testbench/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
   typedef struct packed {
      logic [31:0] data;
      logic        err;
   } sit_exp_type;
   localparam logic [31:0] IE = 32'h1 << sit_pkg::CTL_IE_BIT;
   localparam logic [31:0] OV = 32'h1 << sit_pkg::CTL_OVF_BIT;
   localparam logic [31:0] WD = 32'h1 << sit_pkg::CTL_WDSRC_BIT;
   localparam logic [31:0] CL = 32'h1 << sit_pkg::CTL_CLR_BIT;
   logic        clk_sys_in, arst_n_in, sub_clk_in, psel, penable, pwrite, pready, pslverr;
   logic        irq28_req_out, irq_out;
   logic [3:0]  tbt_tap_in, wd_tap_out;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rnd;
   logic [14:0] stab_tap_out;
   sit_exp_type exp_q[$];
   sit_exp_type e;
   int          n_errors, compares;

   sit_interval_timer uut (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in), .sub_clk_in(sub_clk_in),
      .tbt_tap_in(tbt_tap_in), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .stab_tap_out(stab_tap_out),
      .wd_tap_out(wd_tap_out), .irq28_req_out(irq28_req_out), .irq_out(irq_out));

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   task automatic print_verdict();
      $display("errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : print_verdict

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   // One APB transfer; the request is held until pready is seen high at an edge.
   task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
      int n;
      n = 0;
      @(posedge clk_sys_in);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= data;
      @(posedge clk_sys_in);
      penable <= 1'b1;
      @(posedge clk_sys_in);
      while (pready !== 1'b1 && n < 16) begin
         @(posedge clk_sys_in);
         n++;
      end
      if (n == 16) begin
         n_errors++;
         print_verdict();
      end
      psel <= 1'b0;
      penable <= 1'b0;
      tbt_tap_in <= rnd[3:0];
      rnd = lfsr(rnd);
   endtask : apb

   task automatic rd(input logic [7:0] addr, input logic [31:0] exp, input logic err);
      exp_q.push_back('{exp, err});
      apb(1'b0, addr, 32'h0);
   endtask : rd

   task automatic wr(input logic [7:0] addr, input logic [31:0] data);
      apb(1'b1, addr, data);
   endtask : wr

   // Sixteen system clocks per sub clock period keeps long intervals inside the run budget.
   task automatic sub_ticks(input int n);
      for (int i = 0; i < n; i++) begin
         sub_clk_in <= 1'b1;
         repeat (8) @(posedge clk_sys_in);
         sub_clk_in <= 1'b0;
         repeat (8) @(posedge clk_sys_in);
      end
   endtask : sub_ticks

   // Read data stands through the access phase, so it is taken at the edge that ends it.
   always @(posedge clk_sys_in) begin
      if (psel && penable && pready && !pwrite && exp_q.size() > 0) begin
         e = exp_q.pop_front();
         check("pslverr", {31'h0, pslverr}, {31'h0, e.err});
         check("prdata", prdata, e.data);
      end
   end

   initial begin
      clk_sys_in = 1'b0;
      forever #25 clk_sys_in = ~clk_sys_in;
   end

   initial begin
      #5ms;
      n_errors++;
      print_verdict();
   end

   initial begin
      {arst_n_in, sub_clk_in, psel, penable, pwrite} = 5'h0;
      paddr = 8'h0;
      pwdata = 32'h0;
      rnd = 32'h0974;
      tbt_tap_in = 4'h5;
      n_errors = 0;
      compares = 0;
      repeat (3) @(posedge clk_sys_in);
      arst_n_in <= 1'b1;
      @(posedge clk_sys_in);
      check("irq28", {31'h0, irq28_req_out}, 32'h0);
      rd(sit_pkg::OFS_CONTROL, 32'h0, 1'b0);
      rd(sit_pkg::OFS_COUNT, 32'h0, 1'b0);
      rd(sit_pkg::OFS_INT_STAT, 32'h0, 1'b0);
      rd(sit_pkg::OFS_INT_MASK, 32'h0, 1'b0);
      rd(8'h10, 32'h0, 1'b1);
      wr(8'h10, rnd);
      rd(8'h10, 32'h0, 1'b1);
      #1 check("wd_tap", {28'h0, wd_tap_out}, {28'h0, tbt_tap_in});
      wr(sit_pkg::OFS_CONTROL, CL);
      sub_ticks(5);
      rd(sit_pkg::OFS_COUNT, 32'h5, 1'b0);
      check("stab_tap", {17'h0, stab_tap_out}, 32'h5);
      wr(sit_pkg::OFS_CONTROL, CL | WD);
      rd(sit_pkg::OFS_COUNT, 32'h0, 1'b0);
      #1 check("wd_tap", {28'h0, wd_tap_out}, 32'h0);
      wr(sit_pkg::OFS_INT_MASK, 32'h1);
      rd(sit_pkg::OFS_INT_MASK, 32'h1, 1'b0);
      wr(sit_pkg::OFS_CONTROL, IE | CL);
      sub_ticks(255);
      rd(sit_pkg::OFS_CONTROL, IE, 1'b0);
      check("irq28", {31'h0, irq28_req_out}, 32'h0);
      sub_ticks(1);
      rd(sit_pkg::OFS_CONTROL, IE | OV, 1'b0);
      check("irq28", {31'h0, irq28_req_out}, 32'h1);
      check("irq_out", {31'h0, irq_out}, 32'h1);
      rd(sit_pkg::OFS_INT_STAT, 32'h1, 1'b0);
      rd(sit_pkg::OFS_INT_STAT, 32'h0, 1'b0);
      #1 check("irq_out", {31'h0, irq_out}, 32'h0);
      wr(sit_pkg::OFS_CONTROL, OV);
      rd(sit_pkg::OFS_CONTROL, OV, 1'b0);
      check("irq28", {31'h0, irq28_req_out}, 32'h0);
      wr(sit_pkg::OFS_CONTROL, 32'h0);
      rd(sit_pkg::OFS_CONTROL, 32'h0, 1'b0);
      wr(sit_pkg::OFS_INT_MASK, 32'h0);
      wr(sit_pkg::OFS_CONTROL, 32'h1 | IE | CL);
      sub_ticks(256);
      rd(sit_pkg::OFS_CONTROL, 32'h1 | IE, 1'b0);
      sub_ticks(256);
      rd(sit_pkg::OFS_CONTROL, 32'h1 | IE | OV, 1'b0);
      check("irq_out", {31'h0, irq_out}, 32'h0);
      rd(sit_pkg::OFS_INT_STAT, 32'h1, 1'b0);
      rd(sit_pkg::OFS_COUNT, 32'h200, 1'b0);
      wr(sit_pkg::OFS_CONTROL, 32'h2 | IE | CL);
      sub_ticks(1023);
      rd(sit_pkg::OFS_CONTROL, 32'h2 | IE, 1'b0);
      sub_ticks(1);
      rd(sit_pkg::OFS_CONTROL, 32'h2 | IE | OV, 1'b0);
      check("irq28", {31'h0, irq28_req_out}, 32'h1);
      rd(sit_pkg::OFS_COUNT, 32'h400, 1'b0);
      rd(sit_pkg::OFS_INT_STAT, 32'h1, 1'b0);
      wr(sit_pkg::OFS_CONTROL, 32'h7 | CL);
      sub_ticks(256);
      rd(sit_pkg::OFS_CONTROL, 32'h7, 1'b0);
      rd(sit_pkg::OFS_INT_STAT, 32'h0, 1'b0);
      repeat (2) @(posedge clk_sys_in);
      print_verdict();
   end
endmodule : testbench
`default_nettype wire
